// [shared/addr_pkg.sv]
// Contract
// RULE_01: Direct mode uses 8-bit instruction address field.
// RULE_02: 8-bit indirect reads pointer from first two registers.
// RULE_03: 16-bit indirect uses whole data pointer.
// RULE_04: Register mode picks register from opcode bits.
// RULE_05: Register-specific instructions imply accumulator, no specifier.
// RULE_06: Immediate mode delivers constant as value.
// RULE_07: Indexed mode adds accumulator to pointer, reads only. The 0x83 form gives address zero instead.
// RULE_08: Bit mode selects one of 256 bits.
// RULE_09: Addressing completes within one or two cycles.
// RULE_10: Bits cover 128 RAM bits plus SFR bits.
// RULE_11: External data only via accumulator, indirect only.
// RULE_12: Bank chosen by status word bank bits.
package addr_pkg;
  // Operand target spaces
  typedef enum logic [2:0] {
    SP_NONE = 3'b000,
    SP_RAM = 3'b001,
    SP_SFR = 3'b010,
    SP_XDATA = 3'b011,
    SP_CODE = 3'b100,
    SP_IMM = 3'b101,
    SP_ACC = 3'b110,
    SP_BIT = 3'b111
  } space_t;
  // Sequencer states
  typedef enum logic [0:0] {
    ST_READY = 1'b0,
    ST_PTR_WAIT = 1'b1
  } state_t;
  // Status word bank field position
  localparam int BANK_LSB = 3;
  // Lowest byte of bit-addressable RAM
  localparam logic [7:0] BIT_RAM_BASE = 8'h20;
  // Direct addresses at or above this fall in the SFR space
  localparam logic [7:0] SFR_FIRST = 8'h80;
  // Pointer-indirect forms take two cycles, others one
  localparam int FAST_CYCLES = 1;
  localparam int PTR_CYCLES = 2;
  // Reset values
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] DATA_RST = 8'h00;
endpackage

// [shared/bank_map_if.sv]
`timescale 1ns/10ps
// Carries bank and register index to the bank mapper and its RAM address back
interface bank_map_if;
  logic [1:0] bank; // Active bank from status word
  logic [2:0] reg_idx; // Register number within bank
  logic [7:0] ram_addr; // Resulting internal RAM byte address
  modport mapper (input bank, input reg_idx, output ram_addr);
  modport user (output bank, output reg_idx, input ram_addr);
endinterface

// [core/bank_reg_map.sv]
`timescale 1ns/10ps
// Maps bank and register number onto the low 32 bytes of internal RAM
module bank_reg_map (
  bank_map_if.mapper map
);
  // Eight registers per bank, banks stacked from address zero
  always_comb begin
    map.ram_addr = {3'b000, map.bank, map.reg_idx}; // RULE_12
  end
endmodule

// [core/operand_addressing_unit.sv]
`timescale 1ns/10ps
// Resolves the operand of one decoded instruction into a space and address
module operand_addressing_unit (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic decode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand_byte_in,
  input wire logic [7:0] psw_in,
  input wire logic [7:0] accumulator_in,
  input wire logic [15:0] sixteen_bit_data_pointer_in,
  input wire logic [7:0] pointer_value_in,
  output logic [2:0] space_out,
  output logic [15:0] addr_out,
  output logic [2:0] bit_index_out,
  output logic [7:0] imm_out,
  output logic ptr_fetch_out,
  output logic done_out,
  output logic busy_out,
  output logic write_ok_out
);
  // Whole register state of the unit
  typedef struct packed {
    addr_pkg::state_t st;
    addr_pkg::space_t space;
    addr_pkg::space_t pend_space; // Target space once pointer arrives
    logic [15:0] addr;
    logic [2:0] bit_index;
    logic [7:0] imm;
    logic ptr_fetch;
    logic done;
    logic write_ok;
  } regs_t;

  regs_t r;
  regs_t next_r;
  bank_map_if map ();
  logic [3:0] hi; // Opcode high nibble
  logic [3:0] lo; // Opcode low nibble
  logic is_bit_op; // Opcode takes a bit address
  logic is_acc_op; // Opcode acts on accumulator alone

  assign hi = opcode_in[7:4];
  assign lo = opcode_in[3:0];

  // Register number: low three opcode bits, or bit 0 for the pointer forms
  assign map.bank = psw_in[addr_pkg::BANK_LSB +: 2]; // RULE_12
  assign map.reg_idx = lo[3] ? lo[2:0] : {2'b00, lo[0]}; // RULE_04 RULE_02

  bank_reg_map mapper_inst (
    .map(map)
  );

  // Bit-address opcodes in the low-nibble-2 and jump-on-bit groups
  always_comb begin
    is_bit_op = 1'b0;
    if (lo == 4'h2) begin
      is_bit_op = (hi == 4'h7) || (hi == 4'h8) || (hi == 4'h9) || (hi == 4'ha) ||
                  (hi == 4'hb) || (hi == 4'hc) || (hi == 4'hd);
    end else if (lo == 4'h0) begin
      is_bit_op = (hi == 4'h1) || (hi == 4'h2) || (hi == 4'h3) || (hi == 4'hb);
    end
  end

  // Accumulator-only opcodes: rotates, inc/dec, mul/div, swap, adjust, clear, complement
  always_comb begin
    is_acc_op = 1'b0;
    if (lo == 4'h4) begin
      is_acc_op = (hi == 4'h0) || (hi == 4'h1) || (hi == 4'h8) || (hi == 4'ha) ||
                  (hi == 4'hc) || (hi == 4'hd) || (hi == 4'he) || (hi == 4'hf);
    end else if (lo == 4'h3) begin
      is_acc_op = (hi <= 4'h3);
    end
  end

  // Next-state decode
  // Pulses default low so each result strobes for one enabled cycle
  // Requests are only looked at in the ready state; busy ones are dropped
  // Order of the tests matters: specific opcodes before the nibble groups
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.ptr_fetch = 1'b0;
    unique case (r.st)
      addr_pkg::ST_READY: begin
        if (decode_valid_in) begin
          next_r.bit_index = 3'b000;
          next_r.imm = addr_pkg::DATA_RST;
          next_r.write_ok = 1'b1;
          next_r.done = 1'b1;
          if (opcode_in == 8'h93 || opcode_in == 8'h83) begin
            // Table lookup, read only: data pointer plus accumulator, or zero for 0x83
            next_r.space = addr_pkg::SP_CODE;
            if (opcode_in == 8'h93) begin
              // Sum wraps at 16 bits, as a program address does
              next_r.addr = sixteen_bit_data_pointer_in + {8'h00, accumulator_in}; // RULE_07
            end else begin
              // Program counter is not an input here, so the address is zero
              // Limitation: the caller adds its own counter and the accumulator for this form
              next_r.addr = addr_pkg::ADDR_RST;
            end
            next_r.write_ok = 1'b0; // RULE_07
          end else if (opcode_in == 8'he0 || opcode_in == 8'hf0) begin
            // External data through the full pointer
            next_r.space = addr_pkg::SP_XDATA; // RULE_11
            next_r.addr = sixteen_bit_data_pointer_in; // RULE_03
            next_r.write_ok = (opcode_in == 8'hf0);
          end else if ((hi == 4'he || hi == 4'hf) && (lo == 4'h2 || lo == 4'h3)) begin
            // External data through a pointer register: fetch it first
            next_r.space = addr_pkg::SP_RAM;
            next_r.addr = {8'h00, map.ram_addr}; // RULE_02
            next_r.pend_space = addr_pkg::SP_XDATA; // RULE_11
            next_r.write_ok = (hi == 4'hf);
            next_r.ptr_fetch = 1'b1;
            next_r.done = 1'b0;
            next_r.st = addr_pkg::ST_PTR_WAIT; // RULE_09
          end else if (is_bit_op) begin
            // One bit of 256: low half in RAM bytes, high half in SFR bytes
            next_r.space = addr_pkg::SP_BIT; // RULE_08
            next_r.bit_index = operand_byte_in[2:0]; // RULE_08
            if (operand_byte_in[7]) begin
              next_r.addr = {8'h00, operand_byte_in[7:3], 3'b000}; // RULE_10
            end else begin
              next_r.addr = {8'h00, addr_pkg::BIT_RAM_BASE + {4'h0, operand_byte_in[6:3]}}; // RULE_10
            end
          end else if (is_acc_op) begin
            // Implied accumulator, no specifier read
            next_r.space = addr_pkg::SP_ACC; // RULE_05
            next_r.addr = addr_pkg::ADDR_RST;
          end else if (lo[3]) begin
            // Register form: bank register from opcode bits
            next_r.space = addr_pkg::SP_RAM; // RULE_04
            next_r.addr = {8'h00, map.ram_addr}; // RULE_04
          end else if (lo == 4'h6 || lo == 4'h7) begin
            // Pointer-register indirect into internal RAM
            next_r.space = addr_pkg::SP_RAM;
            next_r.addr = {8'h00, map.ram_addr}; // RULE_02
            next_r.pend_space = addr_pkg::SP_RAM;
            next_r.ptr_fetch = 1'b1;
            next_r.done = 1'b0;
            next_r.st = addr_pkg::ST_PTR_WAIT; // RULE_09
          end else if (lo == 4'h5 && opcode_in != 8'ha5) begin
            // Direct byte: RAM below the SFR boundary, SFR above
            next_r.addr = {8'h00, operand_byte_in}; // RULE_01
            if (operand_byte_in >= addr_pkg::SFR_FIRST) begin
              next_r.space = addr_pkg::SP_SFR; // RULE_01
            end else begin
              next_r.space = addr_pkg::SP_RAM; // RULE_01
            end
          end else if (lo == 4'h4) begin
            // Constant is the operand itself
            next_r.space = addr_pkg::SP_IMM; // RULE_06
            next_r.imm = operand_byte_in; // RULE_06
            next_r.addr = addr_pkg::ADDR_RST;
            next_r.write_ok = 1'b0;
          end else begin
            // Branches and reserved codes carry no data operand
            next_r.space = addr_pkg::SP_NONE;
            next_r.addr = addr_pkg::ADDR_RST;
            next_r.write_ok = 1'b0;
          end
        end
      end
      addr_pkg::ST_PTR_WAIT: begin
        // Pointer byte now on the RAM read port; eight bits wide
        next_r.space = r.pend_space;
        next_r.addr = {8'h00, pointer_value_in}; // RULE_02
        next_r.done = 1'b1;
        next_r.st = addr_pkg::ST_READY; // RULE_09
      end
    endcase
  end

  // Single register stage; clock enable freezes everything
  // Reset acts whatever the enable, so a frozen core still starts clean
  // Every field is reset to a constant, none from live inputs
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      r.st <= addr_pkg::ST_READY;
      r.space <= addr_pkg::SP_NONE;
      r.pend_space <= addr_pkg::SP_NONE;
      r.addr <= addr_pkg::ADDR_RST;
      r.bit_index <= 3'b000;
      r.imm <= addr_pkg::DATA_RST;
      r.ptr_fetch <= 1'b0;
      r.done <= 1'b0;
      r.write_ok <= 1'b0;
    end else if (ce_in) begin
      r <= next_r;
    end
  end

  // Outputs straight from the state register
  // Busy is decoded from the state bit alone, so it never glitches
  // Result fields hold until the next accepted request overwrites them
  assign space_out = r.space;
  assign addr_out = r.addr;
  assign bit_index_out = r.bit_index;
  assign imm_out = r.imm;
  assign ptr_fetch_out = r.ptr_fetch;
  assign done_out = r.done;
  assign busy_out = (r.st == addr_pkg::ST_PTR_WAIT);
  assign write_ok_out = r.write_ok;
endmodule

// [dv/operand_addressing_unit_asserts.sv]
`timescale 1ns/10ps
// Checks resolved operands against the request that caused them
module operand_addressing_unit_asserts (
  input wire logic clock_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic decode_valid_in,
  input wire logic [7:0] opcode_in,
  input wire logic [7:0] operand_byte_in,
  input wire logic [7:0] psw_in,
  input wire logic [7:0] pointer_value_in,
  input wire logic [2:0] space_out,
  input wire logic [15:0] addr_out,
  input wire logic ptr_fetch_out,
  input wire logic done_out,
  input wire logic busy_out,
  input wire logic write_ok_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (srst_in);
  // Request accepted on this edge
  logic take;
  assign take = ce_in && decode_valid_in && !busy_out;
  fetch_busy_a: assert property (ptr_fetch_out |-> busy_out)
    else $error("pointer fetch without busy");
  fetch_bank_a: assert property (ptr_fetch_out |-> addr_out == {11'h000, $past(psw_in[4:3]), 2'b00, $past(opcode_in[0])})
    else $error("pointer register address wrong");
  pointer_use_a: assert property (ptr_fetch_out && ce_in |=> done_out && addr_out == {8'h00, $past(pointer_value_in)})
    else $error("indirect address not pointer content");
  answer_time_a: assert property (take |=> done_out ^ ptr_fetch_out)
    else $error("no answer one cycle after request");
  direct_addr_a: assert property (take && opcode_in == 8'he5 |=> addr_out == {8'h00, $past(operand_byte_in)})
    else $error("direct address wrong");
  direct_space_a: assert property (take && opcode_in == 8'he5 |=> space_out == ($past(operand_byte_in[7]) ? 3'h2 : 3'h1))
    else $error("direct space wrong");
  imm_ro_a: assert property (done_out && space_out == addr_pkg::SP_IMM |-> !write_ok_out)
    else $error("immediate marked writable");
  code_ro_a: assert property (done_out && space_out == addr_pkg::SP_CODE |-> !write_ok_out)
    else $error("code space marked writable");
  bit_byte_a: assert property (done_out && space_out == addr_pkg::SP_BIT |-> (addr_out[7] ? addr_out[2:0] == 3'h0 : addr_out[7:4] == 4'h2))
    else $error("bit byte address outside bit areas");
  // Main scenarios reached
  cover property (ptr_fetch_out ##1 done_out);
  cover property (done_out && space_out == addr_pkg::SP_BIT);
  cover property (done_out && space_out == addr_pkg::SP_CODE);
endmodule
bind operand_addressing_unit operand_addressing_unit_asserts i_chk (.*);

// [dv/pointer_ram_model.sv]
`timescale 1ns/10ps
// Internal RAM seen from the pointer fetch side
module pointer_ram_model (
  input wire logic clock_in,
  input wire logic ptr_fetch_in,
  input wire logic [7:0] addr_in,
  output logic [7:0] value_out
);
  // Last value shown, inverted while idle so stale data never looks valid
  logic [7:0] last = 8'h00;
  // Content is the address mixed with a fixed pattern
  assign value_out = ptr_fetch_in ? (addr_in ^ 8'ha5) : ~last;
  // Remember what was shown
  always @(posedge clock_in) begin
    last <= value_out;
  end
endmodule

// [dv/operand_addressing_unit_test.sv]
`timescale 1ns/10ps
// Sends one instruction at a time and judges the resolved operand
module operand_addressing_unit_test;
  logic clock_in = 1'b0;
  logic srst_in = 1'b1;
  logic dv = 1'b0;
  logic ce = 1'b1;
  logic [7:0] op = 8'h00, opnd = 8'h00, psw = 8'h00, acc = 8'h00, ptr_val;
  logic [15:0] sixteen_bit_data_pointer = 16'h0000, addr_out;
  logic [2:0] space_out, bit_index_out;
  logic [7:0] imm_out;
  logic ptr_fetch_out, done_out, busy_out, write_ok_out;
  int num_errors = 0;
  int total_checks = 0;
  // Clock of 50 ns
  always #25 clock_in = ~clock_in;
  operand_addressing_unit i_dut (.clock_in(clock_in), .srst_in(srst_in), .ce_in(ce), .decode_valid_in(dv),
    .opcode_in(op), .operand_byte_in(opnd), .psw_in(psw), .accumulator_in(acc), .sixteen_bit_data_pointer_in(sixteen_bit_data_pointer),
    .pointer_value_in(ptr_val), .space_out(space_out), .addr_out(addr_out), .bit_index_out(bit_index_out),
    .imm_out(imm_out), .ptr_fetch_out(ptr_fetch_out), .done_out(done_out), .busy_out(busy_out),
    .write_ok_out(write_ok_out));
  pointer_ram_model i_ram (.clock_in(clock_in), .ptr_fetch_in(ptr_fetch_out), .addr_in(addr_out[7:0]),
    .value_out(ptr_val));
  // Compare and count
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One instruction, wait for done under a bound, judge space and address
  task automatic run(input logic [7:0] o, input logic [7:0] b, input logic [2:0] sp, input logic [15:0] ad);
    int n;
    @(posedge clock_in) #2;
    dv = 1'b1;
    op = o;
    opnd = b;
    @(posedge clock_in) #2;
    dv = 1'b0;
    n = 0;
    while (done_out !== 1'b1 && n < 8) begin
      @(posedge clock_in) #2;
      n++;
    end
    check("done", 16'h0001, {15'h0000, done_out});
    check("space", {13'h0000, sp}, {13'h0000, space_out});
    check("addr", ad, addr_out);
  endtask
  // Pointer register into external data, watched edge by edge, then full-pointer write and 0x83 lookup
  task automatic t_ptr();
    psw = 8'h08;
    @(posedge clock_in) #2;
    dv = 1'b1;
    op = 8'he2;
    opnd = 8'h00;
    @(posedge clock_in) #2;
    dv = 1'b0;
    check("fetch", 16'h0001, {15'h0000, ptr_fetch_out});
    check("busy", 16'h0001, {15'h0000, busy_out});
    check("ptrreg", 16'h0008, addr_out);
    @(posedge clock_in) #2;
    check("done", 16'h0001, {15'h0000, done_out});
    check("busy", 16'h0000, {15'h0000, busy_out});
    check("space", 16'h0003, {13'h0000, space_out});
    check("addr", 16'h00ad, addr_out);
    check("wok", 16'h0000, {15'h0000, write_ok_out});
    run(8'hf0, 8'h00, 3'h3, 16'h12f8);
    check("wok", 16'h0001, {15'h0000, write_ok_out});
    run(8'h83, 8'h00, 3'h4, 16'h0000);
  endtask
  // Enable low must freeze the last result
  task automatic t_freeze();
    run(8'he5, 8'h44, 3'h1, 16'h0044);
    @(posedge clock_in) #2;
    ce = 1'b0;
    dv = 1'b1;
    op = 8'he5;
    opnd = 8'h55;
    @(posedge clock_in) #2;
    dv = 1'b0;
    ce = 1'b1;
    check("frozen", 16'h0044, addr_out);
    check("nodone", 16'h0000, {15'h0000, done_out});
  endtask
  // Direct: low half is RAM, upper half is special function space
  task automatic t_direct();
    run(8'he5, 8'h7f, 3'h1, 16'h007f);
    run(8'he5, 8'h90, 3'h2, 16'h0090);
    check("wok", 16'h0001, {15'h0000, write_ok_out});
  endtask
  // Pointer indirect and register modes in nondefault banks
  task automatic t_bank();
    psw = 8'h10;
    run(8'he7, 8'h00, 3'h1, 16'h00b4);
    psw = 8'h08;
    run(8'heb, 8'h00, 3'h1, 16'h000b);
  endtask
  // Request during busy must be ignored
  task automatic t_refuse();
    run(8'he5, 8'h30, 3'h1, 16'h0030);
    @(posedge clock_in) #2;
    dv = 1'b1;
    op = 8'he6;
    @(posedge clock_in) #2;
    op = 8'h74;
    @(posedge clock_in) #2;
    dv = 1'b0;
    check("refused", {13'h0000, 3'h1}, {13'h0000, space_out});
    check("ptraddr", 16'h00ad, addr_out);
  endtask
  // Accumulator, immediate, indexed code and external data
  task automatic t_misc();
    run(8'he4, 8'h00, 3'h6, 16'h0000);
    run(8'h74, 8'h5a, 3'h5, 16'h0000);
    check("imm", 16'h005a, {8'h00, imm_out});
    sixteen_bit_data_pointer = 16'h12f8;
    acc = 8'h10;
    run(8'h93, 8'h00, 3'h4, 16'h1308);
    check("wok", 16'h0000, {15'h0000, write_ok_out});
    run(8'he0, 8'h00, 3'h3, 16'h12f8);
  endtask
  // Bit mode in RAM and in special function space
  task automatic t_bit();
    run(8'ha2, 8'h0b, 3'h7, 16'h0021);
    check("bit", 16'h0003, {13'h0000, bit_index_out});
    run(8'ha2, 8'hd7, 3'h7, 16'h00d0);
    check("bit", 16'h0007, {13'h0000, bit_index_out});
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clock_in);
    #2 srst_in = 1'b0;
    t_direct();
    t_bank();
    t_refuse();
    t_misc();
    t_ptr();
    t_freeze();
    t_bit();
    wrap_up();
  end
  // Hang guard, far beyond the fewer than fifty cycles needed
  initial begin
    #200000;
    num_errors++;
    wrap_up();
  end
endmodule
